// *** design/acr_regs.svh ***
// register indices, field positions and reset values of the channel configuration bank
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_IDX_W            7
`define ACR_IDX_TEMP_CTRL    7'h29
`define ACR_IDX_CFG_BASE     7'h30
`define ACR_IDX_CFG_LAST     7'h37
`define ACR_IDX_SEQ_MODE     7'h38
`define ACR_IDX_IRQ_STATUS   7'h39
`define ACR_IDX_IRQ_ENABLE   7'h3a
`define ACR_IDX_IRQ_CLEAR    7'h3b
`define ACR_IDX_EFF_BASE     7'h40
`define ACR_IDX_EFF_LAST     7'h47

`define ACR_TEMP_EN_BIT      0
`define ACR_TEMP_WMASK       8'h01
`define ACR_TEMP_RESET       8'h00

`define ACR_CFG_TD_BIT       7
`define ACR_CFG_POL_BIT      6
`define ACR_CFG_PAIR_MSB     5
`define ACR_CFG_PAIR_LSB     4
`define ACR_CFG_HIZ_BIT      3
`define ACR_CFG_OSR_MSB      1
`define ACR_CFG_OSR_LSB      0
`define ACR_CFG_WMASK        8'hfb
`define ACR_CFG_RESET        8'h08

`define ACR_SEQ_WMASK        8'h03
`define ACR_IRQ_RESET        16'h0000

`define ACR_PAIR_REFERENCE_GROUND_PIN      2'h0
`define ACR_PAIR_COMMON      2'h1
`define ACR_PAIR_EVEN_ODD    2'h2
`define ACR_PAIR_INVALID     2'h3

`define ACR_OSR_1            2'h0
`define ACR_OSR_4            2'h1
`define ACR_OSR_16           2'h2
`define ACR_OSR_64           2'h3

`define ACR_RATIO_1          7'h01
`define ACR_RATIO_4          7'h04
`define ACR_RATIO_16         7'h10
`define ACR_RATIO_64         7'h40

`define ACR_WIDTH_BASE       5'h10
`define ACR_WIDTH_OSR4       5'h11
`define ACR_WIDTH_OSR16      5'h12
`define ACR_WIDTH_OSR64      5'h13

`endif

// *** design/acr_pkg.sv ***
// types shared by the channel configuration bank
`default_nettype none
package acr_pkg;

  // sequencer mode field; off keeps the channel-zero view
  typedef enum logic [1:0] {
    ACR_SEQ_OFF      = 2'h0,
    ACR_SEQ_STANDARD = 2'h1,
    ACR_SEQ_ADVANCED = 2'h2,
    ACR_SEQ_SPARE    = 2'h3
  } acr_seq_mode_t;

  // one-hot pairing classes
  typedef enum logic [3:0] {
    ACR_PK_REFERENCE_GROUND_PIN   = 4'h1,
    ACR_PK_COMMON   = 4'h2,
    ACR_PK_EVEN_ODD = 4'h4,
    ACR_PK_INVALID  = 4'h8
  } acr_pair_kind_t;

endpackage
`default_nettype wire

// *** design/acr_chan_decode.sv ***
// per-input decode of pairing and oversampling fields
`timescale 1ns/100ps
`default_nettype none
`include "acr_regs.svh"

module acr_chan_decode
  import acr_pkg::*;
(
  input  wire logic [1:0] pair_sel,
  input  wire logic [1:0] osr_sel,
  output logic      [3:0] pair_kind,
  output logic      [6:0] ratio,
  output logic      [4:0] result_width
);

  always_comb begin
    case (pair_sel)
      `ACR_PAIR_REFERENCE_GROUND_PIN:   pair_kind = ACR_PK_REFERENCE_GROUND_PIN;
      `ACR_PAIR_COMMON:   pair_kind = ACR_PK_COMMON;
      `ACR_PAIR_EVEN_ODD: pair_kind = ACR_PK_EVEN_ODD;
      default:            pair_kind = ACR_PK_INVALID;
    endcase
  end

  always_comb begin
    case (osr_sel)
      `ACR_OSR_4: begin
        ratio        = `ACR_RATIO_4;
        result_width = `ACR_WIDTH_OSR4;
      end
      `ACR_OSR_16: begin
        ratio        = `ACR_RATIO_16;
        result_width = `ACR_WIDTH_OSR16;
      end
      `ACR_OSR_64: begin
        ratio        = `ACR_RATIO_64;
        result_width = `ACR_WIDTH_OSR64;
      end
      default: begin
        ratio        = `ACR_RATIO_1;
        result_width = `ACR_WIDTH_BASE;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** design/acr_config_bank.sv ***
// channel configuration register bank with wishbone slave and alert interrupt
// Behaviour
// - temp sensor joins sequence when enabled, sequencer on
// - standard mode: channel zero enables detection everywhere
// - advanced mode: each register enables own input
// - alert flags only while detection enabled
// - polarity always from input's own register
// - pairing decode: ground, common, even-odd, invalid
// - pairing from channel zero or own register
// - high-impedance bit per mode, resets to one
// - oversampling decode: ratios 1, 4, 16, 64
// - result widens to 17, 18, 19 bits
// - oversampling ratio from channel zero or own
`timescale 1ns/100ps
`default_nettype none
`include "acr_regs.svh"

module acr_config_bank
  import acr_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int ADR_W  = 9
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [NUM_CH-1:0]     upper_hit,
  input  wire logic [NUM_CH-1:0]     lower_hit,
  output logic                       temp_sensor_in_sequence,
  output logic      [NUM_CH-1:0]     threshold_detect_on,
  output logic      [NUM_CH-1:0]     polarity_bipolar,
  output logic      [2*NUM_CH-1:0]   pin_pairing_select,
  output logic      [NUM_CH-1:0]     input_high_impedance_on,
  output logic      [2*NUM_CH-1:0]   oversampling_ratio_select,
  output logic      [NUM_CH-1:0]     pair_reference_ground,
  output logic      [NUM_CH-1:0]     pair_common_input,
  output logic      [NUM_CH-1:0]     pair_even_odd,
  output logic      [NUM_CH-1:0]     pair_invalid,
  output logic      [7*NUM_CH-1:0]   oversampling_ratio,
  output logic      [5*NUM_CH-1:0]   result_width,
  output logic      [NUM_CH-1:0]     upper_alert_flag,
  output logic      [NUM_CH-1:0]     lower_alert_flag,
  output logic                       irq
);

  // offsets 0x30..0x37 cap the bank at eight inputs
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
    $error("acr_config_bank: NUM_CH must be 1 to 8");
  end
  // the index sits in address bits 8:2; fewer bits would alias registers
  if (ADR_W < `ACR_IDX_W + 2) begin : g_bad_adr_w
    $error("acr_config_bank: ADR_W too small for the register map");
  end
  // the configuration and effective groups must not spill over their ends
  if (`ACR_IDX_CFG_BASE + NUM_CH - 1 > `ACR_IDX_CFG_LAST) begin : g_bad_cfg_span
    $error("acr_config_bank: configuration registers overrun their group");
  end
  if (`ACR_IDX_EFF_BASE + NUM_CH - 1 > `ACR_IDX_EFF_LAST) begin : g_bad_eff_span
    $error("acr_config_bank: effective views overrun their group");
  end

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] cfg;
    logic [7:0]             temp;
    logic [1:0]             seq_mode;
    logic [2*NUM_CH-1:0]    irq_status;
    logic [2*NUM_CH-1:0]    irq_enable;
    logic                   ack;
    logic [31:0]            dat;
    logic                   temp_in_seq;
    logic [NUM_CH-1:0]      td;
    logic [NUM_CH-1:0]      pol;
    logic [NUM_CH-1:0][1:0] pair;
    logic [NUM_CH-1:0]      hiz;
    logic [NUM_CH-1:0][1:0] osr;
    logic [NUM_CH-1:0][3:0] pair_kind;
    logic [NUM_CH-1:0][6:0] ratio;
    logic [NUM_CH-1:0][4:0] width;
    logic [NUM_CH-1:0]      upper;
    logic [NUM_CH-1:0]      lower;
    logic                   irq;
  } acr_state_t;

  acr_state_t state;
  acr_state_t next_state;

  logic [`ACR_IDX_W-1:0]  reg_idx;
  logic                   bus_req;
  logic                   bus_wr;
  logic                   adv_mode;
  logic                   seq_on;
  logic [NUM_CH-1:0][7:0] eff_cfg;
  logic [NUM_CH-1:0][3:0] dec_pair_kind;
  logic [NUM_CH-1:0][6:0] dec_ratio;
  logic [NUM_CH-1:0][4:0] dec_width;
  logic [2*NUM_CH-1:0]    irq_events;
  logic [2*NUM_CH-1:0]    irq_clear;
  logic [31:0]            read_value;
  logic [2*NUM_CH-1:0]    enable_mask;
  logic [NUM_CH-1:0]      cfg_hit;
  logic [NUM_CH-1:0]      eff_hit;
  logic [NUM_CH-1:0]      cfg_wr;
  logic [NUM_CH-1:0][7:0] eff_view;
  logic                   temp_wr;
  logic                   seq_wr;
  logic                   enable_wr;
  logic                   clear_wr;

  assign reg_idx  = wb_adr_i[`ACR_IDX_W+1:2];
  assign bus_req  = wb_cyc_i & wb_stb_i;
  // writes land only on the edge where the master sees ack
  assign bus_wr   = bus_req & wb_we_i & state.ack;
  // one strobe per destination; the byte-wide registers listen to lane 0 only
  assign temp_wr   = bus_wr & wb_sel_i[0] & (reg_idx == `ACR_IDX_TEMP_CTRL);
  assign seq_wr    = bus_wr & wb_sel_i[0] & (reg_idx == `ACR_IDX_SEQ_MODE);
  assign enable_wr = bus_wr & (reg_idx == `ACR_IDX_IRQ_ENABLE);
  assign clear_wr  = bus_wr & (reg_idx == `ACR_IDX_IRQ_CLEAR);

  // spare code keeps the channel-zero view with the sequencer idle
  always_comb begin
    adv_mode = 1'b0;
    seq_on   = 1'b0;
    case (state.seq_mode)
      ACR_SEQ_STANDARD: begin
        seq_on = 1'b1;
      end
      ACR_SEQ_ADVANCED: begin
        adv_mode = 1'b1;
        seq_on   = 1'b1;
      end
      default: begin
        adv_mode = 1'b0;
        seq_on   = 1'b0;
      end
    endcase
  end

  // effective per-input view; polarity is patched in per channel below
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      logic [7:0] src;
      assign src = adv_mode ? state.cfg[g] : state.cfg[0];
      assign eff_cfg[g] = {src[`ACR_CFG_TD_BIT],
                           state.cfg[g][`ACR_CFG_POL_BIT],
                           src[`ACR_CFG_PAIR_MSB:`ACR_CFG_PAIR_LSB],
                           src[`ACR_CFG_HIZ_BIT],
                           1'b0,
                           src[`ACR_CFG_OSR_MSB:`ACR_CFG_OSR_LSB]};

      // one comparator per register keeps the muxes free of search loops
      localparam int CFG_IDX = `ACR_IDX_CFG_BASE + g;
      localparam int EFF_IDX = `ACR_IDX_EFF_BASE + g;
      assign cfg_hit[g]  = (reg_idx == CFG_IDX[`ACR_IDX_W-1:0]);
      assign eff_hit[g]  = (reg_idx == EFF_IDX[`ACR_IDX_W-1:0]);
      assign cfg_wr[g]   = bus_wr & wb_sel_i[0] & cfg_hit[g];
      assign eff_view[g] = {state.td[g], state.pol[g], state.pair[g],
                            state.hiz[g], 1'b0, state.osr[g]};

      acr_chan_decode u_decode (
        .pair_sel     (eff_cfg[g][`ACR_CFG_PAIR_MSB:`ACR_CFG_PAIR_LSB]),
        .osr_sel      (eff_cfg[g][`ACR_CFG_OSR_MSB:`ACR_CFG_OSR_LSB]),
        .pair_kind    (dec_pair_kind[g]),
        .ratio        (dec_ratio[g]),
        .result_width (dec_width[g])
      );

      // flags follow the registered enable, so a late enable costs a cycle
      assign irq_events[g]        = state.td[g] & upper_hit[g];
      assign irq_events[NUM_CH+g] = state.td[g] & lower_hit[g];

      assign pin_pairing_select[2*g+1:2*g]        = state.pair[g];
      assign oversampling_ratio_select[2*g+1:2*g] = state.osr[g];
      assign oversampling_ratio[7*g+6:7*g]        = state.ratio[g];
      assign result_width[5*g+4:5*g]              = state.width[g];
      assign pair_reference_ground[g]             = state.pair_kind[g][0];
      assign pair_common_input[g]                 = state.pair_kind[g][1];
      assign pair_even_odd[g]                     = state.pair_kind[g][2];
      assign pair_invalid[g]                      = state.pair_kind[g][3];
    end
  endgenerate

  // clear mask from the write-only clear register, by byte lane
  always_comb begin
    logic [15:0] lanes;
    lanes = 16'h0000;
    if (clear_wr) begin
      if (wb_sel_i[0]) begin
        lanes[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        lanes[15:8] = wb_dat_i[15:8];
      end
    end
    irq_clear = lanes[2*NUM_CH-1:0];
  end

  // enable lanes, so a byte-wide master can update one half alone
  always_comb begin
    logic [15:0] lanes;
    lanes = 16'h0000;
    if (enable_wr) begin
      if (wb_sel_i[0]) begin
        lanes[7:0] = 8'hff;
      end
      if (wb_sel_i[1]) begin
        lanes[15:8] = 8'hff;
      end
    end
    enable_mask = lanes[2*NUM_CH-1:0];
  end

  // read mux; unmapped and write-only indices read zero
  always_comb begin
    read_value = 32'h0000_0000;
    case (reg_idx)
      `ACR_IDX_TEMP_CTRL: begin
        read_value[7:0] = state.temp & `ACR_TEMP_WMASK;
      end
      `ACR_IDX_SEQ_MODE: begin
        read_value[1:0] = state.seq_mode;
      end
      `ACR_IDX_IRQ_STATUS: begin
        read_value[2*NUM_CH-1:0] = state.irq_status;
      end
      `ACR_IDX_IRQ_ENABLE: begin
        read_value[2*NUM_CH-1:0] = state.irq_enable;
      end
      `ACR_IDX_IRQ_CLEAR: begin
        // write-only, so a stale clear mask never reads back
        read_value = 32'h0000_0000;
      end
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (cfg_hit[i]) begin
            read_value[7:0] = state.cfg[i] & `ACR_CFG_WMASK;
          end
          if (eff_hit[i]) begin
            read_value[7:0] = eff_view[i];
          end
        end
      end
    endcase
  end

  always_comb begin
    next_state = state;

    // classic single-cycle answer: ack one cycle after the request, then drop
    next_state.ack = bus_req & ~state.ack;
    if (bus_req && !state.ack) begin
      next_state.dat = read_value;
    end

    if (temp_wr) begin
      next_state.temp = wb_dat_i[7:0] & `ACR_TEMP_WMASK;
    end
    if (seq_wr) begin
      next_state.seq_mode = wb_dat_i[1:0];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (cfg_wr[i]) begin
        next_state.cfg[i] = wb_dat_i[7:0] & `ACR_CFG_WMASK;
      end
    end

    next_state.irq_enable = (state.irq_enable & ~enable_mask) |
                            (wb_dat_i[2*NUM_CH-1:0] & enable_mask);

    // a new event in the clearing cycle survives the clear
    next_state.irq_status = (state.irq_status & ~irq_clear) | irq_events;
    // registered, so irq trails its status bit by one cycle
    next_state.irq        = |(state.irq_status & state.irq_enable);

    next_state.temp_in_seq = state.temp[`ACR_TEMP_EN_BIT] & seq_on;
    for (int i = 0; i < NUM_CH; i++) begin
      next_state.td[i]        = eff_cfg[i][`ACR_CFG_TD_BIT];
      next_state.pol[i]       = eff_cfg[i][`ACR_CFG_POL_BIT];
      next_state.pair[i]      = eff_cfg[i][`ACR_CFG_PAIR_MSB:`ACR_CFG_PAIR_LSB];
      next_state.hiz[i]       = eff_cfg[i][`ACR_CFG_HIZ_BIT];
      next_state.osr[i]       = eff_cfg[i][`ACR_CFG_OSR_MSB:`ACR_CFG_OSR_LSB];
      next_state.pair_kind[i] = dec_pair_kind[i];
      next_state.ratio[i]     = dec_ratio[i];
      next_state.width[i]     = dec_width[i];
      next_state.upper[i]     = irq_events[i];
      next_state.lower[i]     = irq_events[NUM_CH+i];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // derived fields must agree with the decode of the reset byte
      for (int i = 0; i < NUM_CH; i++) begin
        state.cfg[i]       <= `ACR_CFG_RESET;
        state.td[i]        <= 1'b0;
        state.pol[i]       <= 1'b0;
        state.pair[i]      <= `ACR_PAIR_REFERENCE_GROUND_PIN;
        state.hiz[i]       <= 1'b1;
        state.osr[i]       <= `ACR_OSR_1;
        state.pair_kind[i] <= ACR_PK_REFERENCE_GROUND_PIN;
        state.ratio[i]     <= `ACR_RATIO_1;
        state.width[i]     <= `ACR_WIDTH_BASE;
        state.upper[i]     <= 1'b0;
        state.lower[i]     <= 1'b0;
      end
      state.temp        <= `ACR_TEMP_RESET;
      state.seq_mode    <= ACR_SEQ_OFF;
      state.irq_status  <= (2*NUM_CH)'(`ACR_IRQ_RESET);
      state.irq_enable  <= (2*NUM_CH)'(`ACR_IRQ_RESET);
      state.ack         <= 1'b0;
      state.dat         <= 32'h0000_0000;
      state.temp_in_seq <= 1'b0;
      state.irq         <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // oversampling must be zero in the command modes; the host owns that
  assign wb_dat_o                = state.dat;
  assign wb_ack_o                = state.ack;
  assign temp_sensor_in_sequence = state.temp_in_seq;
  assign threshold_detect_on     = state.td;
  assign polarity_bipolar        = state.pol;
  assign input_high_impedance_on = state.hiz;
  assign upper_alert_flag        = state.upper;
  assign lower_alert_flag        = state.lower;
  assign irq                     = state.irq;

endmodule
`default_nettype wire

// *** verif/acr_config_bank_chk.sv ***
// bus, alert and decode assertions of the configuration bank
`timescale 1ns/100ps
`default_nettype none
module acr_config_bank_chk #(
  parameter int NUM_CH = 8
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic [31:0]           wb_dat_o,
  input wire logic [NUM_CH-1:0]     upper_hit,
  input wire logic [NUM_CH-1:0]     lower_hit,
  input wire logic [NUM_CH-1:0]     threshold_detect_on,
  input wire logic [NUM_CH-1:0]     upper_alert_flag,
  input wire logic [NUM_CH-1:0]     lower_alert_flag,
  input wire logic [NUM_CH-1:0]     pair_reference_ground,
  input wire logic [NUM_CH-1:0]     pair_common_input,
  input wire logic [NUM_CH-1:0]     pair_even_odd,
  input wire logic [NUM_CH-1:0]     pair_invalid,
  input wire logic [7*NUM_CH-1:0]   oversampling_ratio,
  input wire logic [5*NUM_CH-1:0]   result_width
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  bus_answer_a: assert property (req_s |=> ack_s) else $error("ack missing");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  upper_gate_a: assert property (upper_alert_flag == $past(threshold_detect_on & upper_hit))
    else $error("upper flag wrong");
  lower_gate_a: assert property (lower_alert_flag == $past(threshold_detect_on & lower_hit))
    else $error("lower flag wrong");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  pair_onehot_a: assert property (
    (pair_reference_ground ^ pair_common_input ^ pair_even_odd ^ pair_invalid) == '1
    && ((pair_reference_ground | pair_common_input) & (pair_even_odd | pair_invalid)) == '0
    && (pair_reference_ground & pair_common_input) == '0 && (pair_even_odd & pair_invalid) == '0)
    else $error("pairing not one-hot");
  ratio_set_a: assert property (oversampling_ratio[6:0] inside {7'h01, 7'h04, 7'h10, 7'h40})
    else $error("ratio illegal");
  width_ratio_a: assert property ((oversampling_ratio[6:0] == 7'h40) == (result_width[4:0] == 5'h13))
    else $error("width not tied to ratio");
endmodule
bind acr_config_bank acr_config_bank_chk #(.NUM_CH(NUM_CH)) acr_config_bank_chk_inst (
  .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .upper_hit(upper_hit), .lower_hit(lower_hit),
  .threshold_detect_on(threshold_detect_on), .upper_alert_flag(upper_alert_flag),
  .lower_alert_flag(lower_alert_flag), .pair_reference_ground(pair_reference_ground),
  .pair_common_input(pair_common_input), .pair_even_odd(pair_even_odd),
  .pair_invalid(pair_invalid), .oversampling_ratio(oversampling_ratio),
  .result_width(result_width));
`default_nettype wire

// *** verif/acr_config_bank_bench.sv ***
// self-checking bench of the configuration bank
`timescale 1ns/100ps
`default_nettype none
module acr_config_bank_bench;
  logic        clk = 1'h0, reset_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [8:0]  adr = 9'h000;
  logic [3:0]  sel = 4'h3;
  logic [31:0] dat = 32'h0000_0000, dat_o, q;
  logic        ack, tsis, irq, temp;
  logic [7:0]  hu = 8'h00, hl = 8'h00, td, pol, hiz, prg, pcm, peo, piv, ua, la;
  logic [15:0] pps, oss, x, seed = 16'h9e49;
  logic [55:0] rat;
  logic [39:0] wid;
  logic [7:0]  cfg [8];
  logic [1:0]  mode;
  int          mismatches = 0, compares = 0, cycles = 0;
  acr_config_bank acr_config_bank_inst (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .upper_hit(hu), .lower_hit(hl), .temp_sensor_in_sequence(tsis),
    .threshold_detect_on(td), .polarity_bipolar(pol), .pin_pairing_select(pps),
    .input_high_impedance_on(hiz), .oversampling_ratio_select(oss),
    .pair_reference_ground(prg), .pair_common_input(pcm), .pair_even_odd(peo),
    .pair_invalid(piv), .oversampling_ratio(rat), .result_width(wid),
    .upper_alert_flag(ua), .lower_alert_flag(la), .irq(irq));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  // decode packed as kind, width, ratio, then the effective byte
  function automatic logic [31:0] expect_ch(int i);
    logic [7:0] s;
    s = (mode == 2'h2) ? cfg[i] : cfg[0];
    return {4'h1 << s[5:4], 5'h10 + s[1:0], 7'h01 << {s[1:0], 1'h0},
            s[7], cfg[i][6], s[5:3], 1'h0, s[1:0]};
  endfunction
  function automatic logic [31:0] seen_ch(int i);
    return {piv[i], peo[i], pcm[i], prg[i], wid[5*i+:5], rat[7*i+:7],
            td[i], pol[i], pps[2*i+:2], hiz[i], 1'h0, oss[2*i+:2]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input int idx, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= 9'(idx * 4);
    dat <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'h1);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rd(input string n, input int idx, input logic [31:0] e);
    wb(1'h0, idx, 16'h0000);
    chk(n, e, q);
  endtask
  task automatic check_all();
    logic [31:0] e;
    repeat (3) @(posedge clk);
    chk("temp out", {31'h0, temp && (mode == 2'h1 || mode == 2'h2)}, {31'h0, tsis});
    for (int i = 0; i < 8; i++) begin
      e = expect_ch(i);
      chk("channel", e, seen_ch(i));
      rd("cfg read", 'h30 + i, {24'h0, cfg[i]});
      rd("effective", 'h40 + i, {24'h0, e[7:0]});
    end
    rd("temp read", 'h29, {31'h0, temp});
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ceiling about ten times the roughly 800 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    mode = 2'h0;
    temp = 1'h0;
    for (int i = 0; i < 8; i++) cfg[i] = 8'h08;
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    check_all();
    rd("unmapped", 'h7f, 32'h0000_0000);
    $display("test reset done");
    // rounds: four standard, two advanced, off, spare
    for (int r = 0; r < 8; r++) begin
      mode = 2'(16'hca55 >> (2 * r));
      for (int i = 0; i < 8; i++) begin
        x = rnd();
        if (i == 0 && r < 4) x[5:0] = {2'(r), x[3:2], 2'(r)};
        cfg[i] = x[7:0] & 8'hfb;
        wb(1'h1, 'h30 + i, x);
      end
      temp = x[0];
      wb(1'h1, 'h29, x);
      wb(1'h1, 'h38, {14'h0000, mode});
      check_all();
      $display("test round %0d done", r);
    end
    wb(1'h1, 'h38, 16'h0002);
    for (int i = 0; i < 8; i++) wb(1'h1, 'h30 + i, (i == 3) ? 16'h0080 : 16'h0000);
    wb(1'h1, 'h3a, 16'h0008);
    @(posedge clk);
    hu <= 8'hff;
    hl <= 8'hff;
    repeat (2) @(posedge clk);
    chk("upper flags", 32'h08, {24'h0, ua});
    chk("lower flags", 32'h08, {24'h0, la});
    hu <= 8'h00;
    hl <= 8'h00;
    rd("status", 'h39, 32'h0808);
    chk("irq raised", 32'h1, {31'h0, irq});
    wb(1'h1, 'h3b, 16'h0008);
    rd("status cleared", 'h39, 32'h0800);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'h1, 'h3b, 16'h0800);
    rd("status empty", 'h39, 32'h0000);
    rd("enable", 'h3a, 32'h0008);
    $display("test alerts done");
    end_of_test();
  end
endmodule
`default_nettype wire
